// *** rtl/psalu_pkg.sv ***
// Package of opcodes, widths and operand carriers for the packed SIMD ALU
package psalu_pkg;
    localparam int VEC_W     = 128;
    localparam int NARROW_W  = 64;
    localparam int LATENCY   = 1;
    localparam logic [15:0] S16_MAX = 16'h7fff;
    localparam logic [15:0] S16_MIN = 16'h8000;
    localparam int SHUF_ZERO_BIT = 7;
    localparam int RND_TOP   = 30;
    localparam int RND_LSB   = 14;

    typedef enum logic [4:0] {
        OP_HADD_W   = 5'h00,
        OP_HADD_WS  = 5'h01,
        OP_HADD_D   = 5'h02,
        OP_HSUB_W   = 5'h03,
        OP_HSUB_WS  = 5'h04,
        OP_HSUB_D   = 5'h05,
        OP_ABS_B    = 5'h06,
        OP_ABS_W    = 5'h07,
        OP_ABS_D    = 5'h08,
        OP_MADD_UBS = 5'h09,
        OP_MULH_RS  = 5'h0a,
        OP_SHUF_B   = 5'h0b,
        OP_NEG_B    = 5'h0c,
        OP_NEG_W    = 5'h0d,
        OP_NEG_D    = 5'h0e
    } psalu_op_t;

    typedef struct packed {
        psalu_op_t        op;
        logic             wide;
        logic [VEC_W-1:0] dst;
        logic [VEC_W-1:0] src;
    } psalu_req_t;

    typedef struct packed {
        psalu_op_t        op;
        logic             wide;
        logic [VEC_W-1:0] res;
    } psalu_rsp_t;
endpackage : psalu_pkg

// *** rtl/psalu_lane.sv ***
// One 16-bit lane: saturating pair sum and rounded multiply-high
`timescale 1ns/10ps
module psalu_lane (
    input  wire logic [15:0] a_i,     // First 16-bit operand
    input  wire logic [15:0] b_i,     // Second 16-bit operand
    input  wire logic        sub_i,   // Subtract b from a
    output logic      [15:0] sat_o,   // Saturated a op b
    output logic      [15:0] wrap_o,  // Wrapped a op b
    output logic      [15:0] mulh_o   // Rounded scaled product
);
    logic signed [16:0] sum;
    logic signed [31:0] prod;
    logic        [17:0] top18;

    // Widened add or subtract for clamping
    assign sum    = sub_i
                  ? $signed({a_i[15], a_i}) - $signed({b_i[15], b_i})
                  : $signed({a_i[15], a_i}) + $signed({b_i[15], b_i});
    assign wrap_o = sum[15:0];
    // Clamp to signed 16-bit range
    assign sat_o  = (sum > 17'sd32767)  ? psalu_pkg::S16_MAX :
                    (sum < -17'sd32768) ? psalu_pkg::S16_MIN : sum[15:0];
    // Product, upper 18 bits, add one, take 16 below the top
    assign prod   = $signed(a_i) * $signed(b_i);
    assign top18  = prod[31:14] + 18'h00001;
    assign mulh_o = top18[16:1];
endmodule : psalu_lane

// *** rtl/psalu.sv ***
// Packed-integer SIMD ALU with one registered result stage
`timescale 1ns/10ps
// How it works
// RL1: Every operation in 64 and 128-bit forms
// RL2: Horizontal word add, wrapped sums packed
// RL3: Horizontal word add, clamped to signed range
// RL4: Horizontal dword add, wrapped sums packed
// RL5: Horizontal word subtract, low minus high
// RL6: Horizontal word subtract with signed clamp
// RL7: Horizontal dword subtract, low minus high
// RL8: Absolute value of bytes, words, dwords
// RL9: Unsigned-by-signed byte multiply, pair add, saturate
// RL10: Word multiply, keep upper eighteen bits
// RL11: Add one, take sixteen below top
// RL12: Shuffle bytes by three or four bit index
// RL13: Control bit seven set gives zero byte
// RL14: Control mask stays unchanged
// RL15: Negate element where source is negative
// RL16: Zero source zeroes, positive keeps element
// RL17: Destination pairs low half, source upper
module psalu #(
    parameter int VEC_W = psalu_pkg::VEC_W  // Widest operand width
) (
    input  wire logic                  sys_clk_i, // Core clock
    input  wire logic                  reset_i,   // Sync reset, high
    input  wire logic                  valid_i,   // Request valid
    input  wire psalu_pkg::psalu_req_t req_i,     // Opcode and operands
    output logic                       valid_o,   // Result valid
    output psalu_pkg::psalu_rsp_t      rsp_o      // Registered result
);
    localparam int NW = VEC_W / 16;
    localparam int ND = VEC_W / 32;
    localparam int NB = VEC_W / 8;

    // Widths other than the documented one are refused
    if (VEC_W != 128) begin : g_chk
        $error("psalu: VEC_W must be 128");
    end

    logic [VEC_W-1:0] dst;
    logic [VEC_W-1:0] src;
    logic [VEC_W-1:0] next_res;
    logic [VEC_W-1:0] ext_d;
    logic [VEC_W-1:0] ext_s;
    logic [15:0]      hs_sat [NW];
    logic [15:0]      hs_wrp [NW];
    logic [15:0]      mh     [NW];
    logic [15:0]      ma_sat [NW];
    logic [15:0]      ha     [NW];
    logic [15:0]      hb     [NW];
    logic             hsub;

    assign dst = req_i.dst;
    assign src = req_i.src;

    // Magnitude of a signed element
    function automatic logic [31:0] abs_f(input logic [31:0] v,
                                          input int w);
        logic [31:0] m;
        m = v[w-1] ? (~v + 32'h1) : v;
        abs_f = m & ((w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1));
    endfunction : abs_f

    // Negate, zero or pass by sign of control element
    function automatic logic [31:0] sgn_f(input logic [31:0] d,
                                          input logic [31:0] s,
                                          input int w);
        logic [31:0] mask;
        logic [31:0] r;
        mask = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
        if ((s & mask) == 32'h0) r = 32'h0;
        else if (s[w-1])         r = (~d + 32'h1) & mask;
        else                     r = d & mask;
        sgn_f = r;
    endfunction : sgn_f

    // Narrow form: upper half of operand ignored, results fill low 64 bits
    always_comb begin
        ext_d = dst;
        ext_s = src;
        if (!req_i.wide) begin
            ext_d[VEC_W-1:VEC_W/2] = '0;
            ext_s[VEC_W-1:VEC_W/2] = '0;
        end
    end

    // Pair operands: dest pairs low, source pairs high in order
    always_comb begin
        int half;
        half = req_i.wide ? NW / 2 : NW / 4;
        for (int k = 0; k < NW; k++) begin
            ha[k] = '0;
            hb[k] = '0;
        end
        // One pair per result word; index wrapped to stay in range
        for (int k = 0; k < NW; k++) begin
            if (k < half) begin  // see RL17
                ha[k] = ext_d[32*(k%4) +: 16];
                hb[k] = ext_d[32*(k%4)+16 +: 16];
            end else if (k < 2 * half) begin
                ha[k] = ext_s[32*((k-half)%4) +: 16];
                hb[k] = ext_s[32*((k-half)%4)+16 +: 16];
            end
        end
    end

    assign hsub = (req_i.op == psalu_pkg::OP_HSUB_W) ||
                  (req_i.op == psalu_pkg::OP_HSUB_WS);

    // Sixteen-bit lanes for pair sums and multiply-high
    for (genvar g = 0; g < NW; g++) begin : g_lane
        psalu_lane u_lane (
            .a_i    (req_i.op == psalu_pkg::OP_MULH_RS ? ext_d[16*g +: 16]
                                                       : ha[g]),
            .b_i    (req_i.op == psalu_pkg::OP_MULH_RS ? ext_s[16*g +: 16]
                                                       : hb[g]),
            .sub_i  (hsub),
            .sat_o  (hs_sat[g]),
            .wrap_o (hs_wrp[g]),
            .mulh_o (mh[g])
        );
    end

    // Unsigned dest byte times signed source byte, pair add, clamp
    always_comb begin
        logic signed [17:0] acc;
        acc = '0;
        for (int k = 0; k < NW; k++) begin
            // Operands widened to 18 bits first so products never wrap
            acc = $signed({10'h000, ext_d[16*k +: 8]}) *  // see RL9
                  $signed({{10{ext_s[16*k+7]}}, ext_s[16*k +: 8]}) +
                  $signed({10'h000, ext_d[16*k+8 +: 8]}) *
                  $signed({{10{ext_s[16*k+15]}}, ext_s[16*k+8 +: 8]});
            ma_sat[k] = (acc > 18'sd32767)  ? psalu_pkg::S16_MAX :
                        (acc < -18'sd32768) ? psalu_pkg::S16_MIN :
                        acc[15:0];
        end
    end

    // Result select by opcode
    always_comb begin
        int half;
        logic [3:0] idx;
        logic [7:0] ctl;
        logic [31:0] a;
        logic [31:0] b;
        half = req_i.wide ? ND / 2 : ND / 4;
        idx = '0;
        ctl = '0;
        a = '0;
        b = '0;
        next_res = '0;
        case (req_i.op)
            psalu_pkg::OP_HADD_W, psalu_pkg::OP_HSUB_W: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] = hs_wrp[k];  // see RL2 RL5
            end
            psalu_pkg::OP_HADD_WS, psalu_pkg::OP_HSUB_WS: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] = hs_sat[k];  // see RL3 RL6
            end
            psalu_pkg::OP_HADD_D, psalu_pkg::OP_HSUB_D: begin
                for (int k = 0; k < ND; k++) begin
                    if (k < half) begin  // see RL17
                        a = ext_d[64*(k%2) +: 32];
                        b = ext_d[64*(k%2)+32 +: 32];
                    end else if (k < 2 * half) begin
                        a = ext_s[64*((k-half)%2) +: 32];
                        b = ext_s[64*((k-half)%2)+32 +: 32];
                    end else begin
                        a = '0;
                        b = '0;
                    end
                    next_res[32*k +: 32] =
                        (req_i.op == psalu_pkg::OP_HSUB_D) ? a - b
                                                           : a + b;
                end  // see RL4 RL7
            end
            psalu_pkg::OP_ABS_B: begin
                for (int k = 0; k < NB; k++)
                    next_res[8*k +: 8] = 8'(abs_f({24'h0, ext_s[8*k +: 8]},
                                                  8));  // see RL8
            end
            psalu_pkg::OP_ABS_W: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] =
                        16'(abs_f({16'h0, ext_s[16*k +: 16]}, 16));
            end
            psalu_pkg::OP_ABS_D: begin
                for (int k = 0; k < ND; k++)
                    next_res[32*k +: 32] = abs_f(ext_s[32*k +: 32], 32);
            end
            psalu_pkg::OP_MADD_UBS: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] = ma_sat[k];
            end
            psalu_pkg::OP_MULH_RS: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] = mh[k];  // see RL10 RL11
            end
            psalu_pkg::OP_SHUF_B: begin
                // Control mask only read, never written back; see RL14
                for (int k = 0; k < NB; k++) begin
                    ctl = ext_s[8*k +: 8];
                    idx = req_i.wide ? ctl[3:0] : {1'b0, ctl[2:0]};
                    if (ctl[psalu_pkg::SHUF_ZERO_BIT])
                        next_res[8*k +: 8] = 8'h00;  // see RL13
                    else
                        next_res[8*k +: 8] = ext_d[8*idx +: 8];  // see RL12
                end
            end
            psalu_pkg::OP_NEG_B: begin
                for (int k = 0; k < NB; k++)
                    next_res[8*k +: 8] = 8'(sgn_f({24'h0, ext_d[8*k +: 8]},
                        {24'h0, ext_s[8*k +: 8]}, 8));  // see RL15 RL16
            end
            psalu_pkg::OP_NEG_W: begin
                for (int k = 0; k < NW; k++)
                    next_res[16*k +: 16] = 16'(sgn_f(
                        {16'h0, ext_d[16*k +: 16]},
                        {16'h0, ext_s[16*k +: 16]}, 16));
            end
            psalu_pkg::OP_NEG_D: begin
                for (int k = 0; k < ND; k++)
                    next_res[32*k +: 32] = sgn_f(ext_d[32*k +: 32],
                                                 ext_s[32*k +: 32], 32);
            end
            default: next_res = '0;
        endcase
        // Narrow form clears the upper half; see RL1
        if (!req_i.wide)
            next_res[VEC_W-1:VEC_W/2] = '0;
    end

    // Valid pipeline stage
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) valid_o <= 1'b0;
        else         valid_o <= valid_i;
    end

    // Result register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rsp_o <= '0;
        end else if (valid_i) begin
            rsp_o.op   <= req_i.op;
            rsp_o.wide <= req_i.wide;
            rsp_o.res  <= next_res;
        end
    end

    // Checks
    property p_lat;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i |=> valid_o;
    endproperty
    a_lat: assert property (p_lat) else $error("result late");  // see RL1

    property p_hadd;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.wide && req_i.op == psalu_pkg::OP_HADD_W |=>
        rsp_o.res[15:0] == 16'($past(req_i.dst[15:0]) +
                               $past(req_i.dst[31:16]));
    endproperty
    a_hadd: assert property (p_hadd) else $error("hadd lane0");  // see RL2

    property p_hsubd;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.wide && req_i.op == psalu_pkg::OP_HSUB_D |=>
        rsp_o.res[95:64] == $past(req_i.src[31:0]) - $past(req_i.src[63:32]);
    endproperty
    a_hsubd: assert property (p_hsubd) else $error("hsubd");  // see RL7 RL17

    property p_sat;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.op == psalu_pkg::OP_HADD_WS &&
        req_i.dst[15:0] == 16'h7fff && req_i.dst[31:16] == 16'h0001 |=>
        rsp_o.res[15:0] == psalu_pkg::S16_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("no clamp");  // see RL3

    property p_shufz;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.op == psalu_pkg::OP_SHUF_B && req_i.src[7] |=>
        rsp_o.res[7:0] == 8'h00;
    endproperty
    a_shufz: assert property (p_shufz) else $error("shuf zero");  // see RL13

    property p_shuf;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.wide && req_i.op == psalu_pkg::OP_SHUF_B &&
        req_i.src[7:0] == 8'h0f |=>
        rsp_o.res[7:0] == $past(req_i.dst[127:120]);
    endproperty
    a_shuf: assert property (p_shuf) else $error("shuf idx");  // see RL12

    property p_narrow;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && !req_i.wide |=> rsp_o.res[127:64] == 64'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper");  // see RL1

    property p_neg;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.op == psalu_pkg::OP_NEG_D && req_i.src[31:0] == 0
        |=> rsp_o.res[31:0] == 32'h0;
    endproperty
    a_neg: assert property (p_neg) else $error("sign zero");  // see RL16

    property p_abs;
        @(posedge sys_clk_i) disable iff (reset_i)
        valid_i && req_i.op == psalu_pkg::OP_ABS_B &&
        req_i.src[7:0] == 8'hff |=> rsp_o.res[7:0] == 8'h01;
    endproperty
    a_abs: assert property (p_abs) else $error("abs");  // see RL8

    c_madd: cover property (@(posedge sys_clk_i)
        valid_i && req_i.op == psalu_pkg::OP_MADD_UBS);
    c_mulh: cover property (@(posedge sys_clk_i)
        valid_i && req_i.op == psalu_pkg::OP_MULH_RS);
    c_narrow: cover property (@(posedge sys_clk_i)
        valid_i && !req_i.wide && req_i.op == psalu_pkg::OP_HSUB_WS);
endmodule : psalu

// *** testbench/psalu_issue.sv ***
// Issue-side model: drives requests into the ALU
`timescale 1ns/10ps
module psalu_issue (
    input  wire logic             sys_clk_i, // Core clock
    output logic                  valid_o,   // Request valid to the ALU
    output psalu_pkg::psalu_req_t req_o      // Opcode and operands
);
    // Quiet bus at time zero
    initial begin
        valid_o = 1'b0;
        req_o   = '0;
    end

    // Present one request just after an edge
    task automatic drive(input psalu_pkg::psalu_req_t r);
        @(posedge sys_clk_i);
        valid_o <= 1'b1;
        req_o   <= r;
    endtask : drive

    // Release; operands turn to junk so stale values never pass
    task automatic idle;
        @(posedge sys_clk_i);
        valid_o <= 1'b0;
        req_o   <= ~req_o;
    endtask : idle
endmodule : psalu_issue

// *** testbench/psalu_test.sv ***
// Self-checking bench for the packed SIMD ALU
`timescale 1ns/10ps
module psalu_test;
    localparam logic [127:0] D1 = 128'h12345678_9abcdef0_7fff0001_8000ffff;
    localparam logic [127:0] S1 = 128'h76543210_fedcba98_00018000_7fff8000;
    localparam logic [127:0] S3 = 128'h80000000_ffffffff_8000ff80_7f01807f;
    logic                  sys_clk_i = 1'b0;
    logic                  reset_i   = 1'b1;
    logic                  valid_i;
    psalu_pkg::psalu_req_t req_i;
    logic                  valid_o;
    psalu_pkg::psalu_rsp_t rsp_o;
    int                    failures  = 0;
    int                    n_checks  = 0;
    int                    cycles    = 0;

    // 25 MHz core clock
    always #20 sys_clk_i = ~sys_clk_i;

    psalu u_dut (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .valid_i   (valid_i),
        .req_i     (req_i),
        .valid_o   (valid_o),
        .rsp_o     (rsp_o)
    );

    psalu_issue u_issue (
        .sys_clk_i (sys_clk_i),
        .valid_o   (valid_i),
        .req_o     (req_i)
    );

    // Signed element i of width w
    function automatic longint el(logic [127:0] x, int i, int w);
        logic [127:0] t;
        t = x >> (i * w);
        case (w)
            8:       return longint'($signed(t[7:0]));
            16:      return longint'($signed(t[15:0]));
            default: return longint'($signed(t[31:0]));
        endcase
    endfunction : el

    // Expected result worked out element by element
    function automatic logic [127:0] ref_res(psalu_pkg::psalu_op_t op,
            logic wide, logic [127:0] d, logic [127:0] s);
        int           w;
        int           h;
        longint       a;
        longint       b;
        longint       v;
        logic [127:0] x;
        logic [127:0] r;
        r = '0;
        case (op)
            psalu_pkg::OP_HADD_D, psalu_pkg::OP_HSUB_D, psalu_pkg::OP_ABS_D,
            psalu_pkg::OP_NEG_D: w = 32;
            psalu_pkg::OP_ABS_B, psalu_pkg::OP_SHUF_B,
            psalu_pkg::OP_NEG_B: w = 8;
            default: w = 16;
        endcase
        h = (wide ? 128 : 64) / (2 * w);
        for (int k = 0; k < 2 * h; k++) begin
            x = (k < h) ? d : s;
            a = el(x, 2 * (k % h), w);
            b = el(x, 2 * (k % h) + 1, w);
            case (op)
                psalu_pkg::OP_HADD_W, psalu_pkg::OP_HADD_WS,
                psalu_pkg::OP_HADD_D: v = a + b;
                psalu_pkg::OP_HSUB_W, psalu_pkg::OP_HSUB_WS,
                psalu_pkg::OP_HSUB_D: v = a - b;
                psalu_pkg::OP_ABS_B, psalu_pkg::OP_ABS_W,
                psalu_pkg::OP_ABS_D: v = el(s, k, w) < 0 ? -el(s, k, w)
                                                         : el(s, k, w);
                psalu_pkg::OP_MADD_UBS:
                    v = (el(d, 2*k, 8) & 255) * el(s, 2*k, 8)
                        + (el(d, 2*k+1, 8) & 255) * el(s, 2*k+1, 8);
                psalu_pkg::OP_MULH_RS:
                    v = (((el(d, k, 16) * el(s, k, 16)) >>> 14) + 1) >>> 1;
                psalu_pkg::OP_SHUF_B: v = el(s, k, 8) < 0 ? 0 :
                        el(d, int'(el(s, k, 8) & (wide ? 15 : 7)), 8);
                psalu_pkg::OP_NEG_B, psalu_pkg::OP_NEG_W, psalu_pkg::OP_NEG_D:
                    v = el(s, k, w) < 0 ? -el(d, k, w) :
                        (el(s, k, w) == 0 ? 0 : el(d, k, w));
                default: v = 0;
            endcase
            if (op inside {psalu_pkg::OP_HADD_WS, psalu_pkg::OP_HSUB_WS,
                           psalu_pkg::OP_MADD_UBS}) begin
                v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
            end
            r = r | ((128'(v) & ((128'h1 << w) - 1)) << (k * w));
        end
        return r;
    endfunction : ref_res

    // One comparison, counted
    task automatic chk(input string nm, input logic [127:0] exp,
                       input logic [127:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask : chk

    // Issue one request and judge pulse, result and tags
    task automatic run(input psalu_pkg::psalu_op_t op, input logic wide,
                       input logic [127:0] d, input logic [127:0] s);
        psalu_pkg::psalu_req_t r;
        r = '{op, wide, d, s};
        u_issue.drive(r);
        u_issue.idle();
        @(negedge sys_clk_i);
        chk("valid", 128'h1, 128'(valid_o));
        chk($sformatf("res op %0h w %0d", op, wide),
            ref_res(op, wide, d, s), rsp_o.res);
        chk("op_wide", 128'({op, wide}), 128'({rsp_o.op, rsp_o.wide}));
        @(negedge sys_clk_i);
        chk("valid_end", 128'h0, 128'(valid_o));
    endtask : run

    // Outputs quiet after reset
    task automatic t_reset;
        @(negedge sys_clk_i);
        chk("reset_valid", 128'h0, 128'(valid_o));
        chk("reset_res", 128'h0, rsp_o.res);
    endtask : t_reset

    // Horizontal adds, wrapped and saturating, both widths
    task automatic t_hadd;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_HADD_W, w[0], D1, S1);
            run(psalu_pkg::OP_HADD_WS, w[0], D1, S1);
            run(psalu_pkg::OP_HADD_D, w[0], D1, S1);
        end
    endtask : t_hadd

    // Horizontal subtracts, low minus high
    task automatic t_hsub;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_HSUB_W, w[0], D1, S1);
            run(psalu_pkg::OP_HSUB_WS, w[0], D1, S1);
            run(psalu_pkg::OP_HSUB_D, w[0], D1, S1);
        end
    endtask : t_hsub

    // Magnitudes including the most negative values
    task automatic t_abs;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_ABS_B, w[0], D1, S3);
            run(psalu_pkg::OP_ABS_W, w[0], D1, S3);
            run(psalu_pkg::OP_ABS_D, w[0], D1, S3);
        end
    endtask : t_abs

    // Byte multiply-add, rounded multiply-high
    task automatic t_mul;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_MADD_UBS, w[0],
                128'hffff0102_80ff00ff_ffff7f80_1234abcd,
                128'h7f7f8080_7f80017f_80807f7f_fedc0123);
            run(psalu_pkg::OP_MULH_RS, w[0],
                128'h80008000_7fff4000_c0000001_ffff1234,
                128'h80007fff_7fff4000_40000001_ffffabcd);
        end
    endtask : t_mul

    // Shuffle with index bit 3 set and zeroing controls
    task automatic t_shuf;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_SHUF_B, w[0],
                128'hf0e1d2c3_b4a59687_78695a4b_3c2d1e0f,
                128'h800f0807_ff000901_8f0a0388_10077e0c);
        end
    endtask : t_shuf

    // Conditional negate: negative and positive controls, zero controls in bytes only
    task automatic t_sign;
        for (int w = 0; w < 2; w++) begin
            run(psalu_pkg::OP_NEG_B, w[0], D1, S3);
            run(psalu_pkg::OP_NEG_W, w[0], D1, S1);
            run(psalu_pkg::OP_NEG_D, w[0], D1, S3);
        end
    endtask : t_sign

    // Back-to-back requests, second with an unused opcode
    task automatic t_b2b;
        psalu_pkg::psalu_req_t a;
        psalu_pkg::psalu_req_t b;
        a = '{psalu_pkg::OP_HADD_W, 1'b1, D1, S1};
        b = '{psalu_pkg::psalu_op_t'(5'h1f), 1'b1, D1, S1};
        u_issue.drive(a);
        u_issue.drive(b);
        @(negedge sys_clk_i);
        chk("b2b_res", ref_res(a.op, 1'b1, D1, S1), rsp_o.res);
        chk("b2b_valid", 128'h1, 128'(valid_o));
        u_issue.idle();
        @(negedge sys_clk_i);
        chk("unknown_res", 128'h0, rsp_o.res);
        chk("unknown_valid", 128'h1, 128'(valid_o));
        @(negedge sys_clk_i);
        chk("b2b_end", 128'h0, 128'(valid_o));
    endtask : t_b2b

    // Counts and verdict
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // Hang guard
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_hadd();
        t_hsub();
        t_abs();
        t_mul();
        t_shuf();
        t_sign();
        t_b2b();
        test_done();
    end
endmodule : psalu_test
